/* eeprom_pkg.sv */
// Shared constants and types for the serial EEPROM command and read port.
package eeprom_pkg;

    // =========================================================================
    // Word and command layout
    // =========================================================================
    localparam int         WORD_W   = 16;    // Bits per stored word.
    localparam int         OP_W     = 2;     // Opcode bits after the start bit.
    localparam int         CNT_W    = 5;     // Width of the bit counter.
    localparam logic [1:0] OP_READ  = 2'h2;  // Read one or more words.
    localparam logic [1:0] OP_WRITE = 2'h1;  // Write one word.
    localparam logic [1:0] OP_ERASE = 2'h3;  // Set one word to all ones.

    // =========================================================================
    // Timing
    // =========================================================================
    localparam int  CLK_HZ           = 10_000_000; // System clock rate.
    localparam real PROG_TIME_TYP_MS = 4.0;        // Typical program time.
    localparam real PROG_TIME_MAX_MS = 8.0;        // Longest program time.
    localparam int  PROG_CYCLES_TYP  =
        int'(PROG_TIME_TYP_MS * 1.0e-3 * CLK_HZ);
    localparam int  PROG_CYCLES_MAX  =
        int'($floor(PROG_TIME_MAX_MS * 1.0e-3 * CLK_HZ));

    // =========================================================================
    // Buffering
    // =========================================================================
    localparam int FIFO_DEPTH = 16;      // Words prefetched for reads.

    // =========================================================================
    // Command sequencer states, Gray coded in the order listed
    // =========================================================================
    typedef enum logic [2:0] {
        ST_WAIT = 3'h0,   // Waiting for the start bit.
        ST_OP   = 3'h1,   // Shifting in the opcode.
        ST_ADDR = 3'h3,   // Shifting in the address.
        ST_DATA = 3'h2,   // Shifting in write data.
        ST_READ = 3'h6,   // Shifting out read data.
        ST_DONE = 3'h7    // Command complete, waiting for deselect.
    } state_e;

endpackage : eeprom_pkg

/* serial_eeprom.sv */
// Serial EEPROM command front end, read path, prefetch FIFO and write timer.
`timescale 1ns/1ns

// =============================================================================
// Word FIFO with valid and ready on both sides
// =============================================================================
module word_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             flush,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [PW-1:0]    rd_ptr;
    logic [PW-1:0]    wr_ptr;
    logic [PW:0]      count;
    logic [PW-1:0]    next_rd_ptr;
    logic [PW-1:0]    next_wr_ptr;
    logic [PW:0]      next_count;
    logic             push;
    logic             pop;

    // Honest full and empty come straight from the occupancy count.
    assign in_ready  = (count != DEPTH[PW:0]);
    assign out_valid = (count != '0);
    assign out_data  = store[rd_ptr];
    assign push      = in_valid && in_ready && !flush;
    assign pop       = out_valid && out_ready && !flush;

    // Pointer and count update; a flush empties the buffer at once.
    always_comb
    begin
        next_rd_ptr = pop  ? rd_ptr + 1'b1 : rd_ptr;
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_count  = count + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
        if (flush)
        begin
            next_rd_ptr = '0;
            next_wr_ptr = '0;
            next_count  = '0;
        end
    end

    // Registers the pointers and stores the pushed word.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rd_ptr <= '0;
            wr_ptr <= '0;
            count  <= '0;
        end
        else
        begin
            rd_ptr <= next_rd_ptr;
            wr_ptr <= next_wr_ptr;
            count  <= next_count;
        end
        if (push)
            store[wr_ptr] <= in_data;
    end

endmodule : word_fifo

// =============================================================================
// Top level
// =============================================================================
module serial_eeprom #(
    parameter int ADDR_W      = 6,
    parameter int PROG_CYCLES = eeprom_pkg::PROG_CYCLES_TYP
) (
    input  wire logic CLK,
    input  wire logic SYS_RST,
    input  wire logic CS,
    input  wire logic SERIAL_CLOCK,
    input  wire logic SERIAL_DATA_IN,
    output logic      DATA_OUT,
    output logic      DATA_OUT_OE
);
    localparam int W  = eeprom_pkg::WORD_W;
    localparam int BW = $clog2(PROG_CYCLES + 1);
    localparam logic [eeprom_pkg::CNT_W-1:0] OP_LAST   =
        eeprom_pkg::CNT_W'(eeprom_pkg::OP_W - 1);
    localparam logic [eeprom_pkg::CNT_W-1:0] ADDR_LAST =
        eeprom_pkg::CNT_W'(ADDR_W - 1);
    localparam logic [eeprom_pkg::CNT_W-1:0] DATA_LAST =
        eeprom_pkg::CNT_W'(W - 1);
    localparam logic [3:0] BITS_LAST = 4'(W - 1);
    localparam logic [BW-1:0] PROG_LOAD = BW'(PROG_CYCLES);

    logic [W-1:0] mem [2**ADDR_W];

    eeprom_pkg::state_e              state, next_state;
    logic [eeprom_pkg::CNT_W-1:0]    cnt, next_cnt;
    logic [eeprom_pkg::OP_W-1:0]     op, next_op;
    logic [ADDR_W-1:0]               addr, next_addr;
    logic [ADDR_W-1:0]               fetch_addr, next_fetch_addr;
    logic [W-1:0]                    wdata, next_wdata;
    logic [W-1:0]                    shreg, next_shreg;
    logic [3:0]                      bits_left, next_bits_left;
    logic [BW-1:0]                   busy_cnt, next_busy_cnt;
    logic                            sk_prev, cs_prev;
    logic                            fetch_en, next_fetch_en;
    logic                            pend, next_pend;
    logic                            verify, next_verify;
    logic                            next_do, next_oe;
    logic                            mem_we;
    logic                            fifo_flush, fifo_pop;
    logic                            fifo_in_ready, fifo_out_valid;
    logic [W-1:0]                    fifo_out;
    logic                            sk_rise, cs_fall, busy;

    assign sk_rise = SERIAL_CLOCK && !sk_prev;
    assign cs_fall = cs_prev && !CS;
    assign busy    = (busy_cnt != '0);

    // Prefetch of sequential read words; stalls while the FIFO is full.
    word_fifo #(
        .WIDTH (W),
        .DEPTH (eeprom_pkg::FIFO_DEPTH)
    ) u_prefetch (
        .clk       (CLK),
        .rst       (SYS_RST),
        .flush     (fifo_flush),
        .in_valid  (fetch_en),
        .in_ready  (fifo_in_ready),
        .in_data   (mem[fetch_addr]),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_out)
    );

    // Command sequencer, output shifter and write timer next values.
    always_comb
    begin
        next_state      = state;
        next_cnt        = cnt;
        next_op         = op;
        next_addr       = addr;
        next_wdata      = wdata;
        next_shreg      = shreg;
        next_bits_left  = bits_left;
        next_pend       = pend;
        next_verify     = verify;
        next_do         = DATA_OUT;
        next_oe         = DATA_OUT_OE;
        next_fetch_en   = fetch_en;
        next_fetch_addr = fetch_addr;
        next_busy_cnt   = busy ? busy_cnt - 1'b1 : busy_cnt;
        mem_we          = 1'b0;
        fifo_flush      = 1'b0;
        fifo_pop        = 1'b0;
        if (fetch_en && fifo_in_ready)
            next_fetch_addr = fetch_addr + 1'b1;
        if (!CS)
        begin
            // Standby: the input phase ends and the output floats.
            next_state    = eeprom_pkg::ST_WAIT;
            next_oe       = 1'b0;
            next_do       = 1'b0;
            next_fetch_en = 1'b0;
            fifo_flush    = 1'b1;
            next_pend     = 1'b0;
            if (cs_fall && pend && !busy)
            begin
                mem_we        = 1'b1;
                next_busy_cnt = PROG_LOAD;
                next_verify   = 1'b1;
            end
        end
        else if (verify && state == eeprom_pkg::ST_WAIT)
        begin
            // Status check: low while programming, high when ready.
            next_oe = 1'b1;
            next_do = !busy;
            if (!busy && DATA_OUT && sk_rise && SERIAL_DATA_IN)
            begin
                next_verify = 1'b0;
                next_oe     = 1'b0;
                next_state  = eeprom_pkg::ST_OP;
                next_cnt    = '0;
            end
        end
        else if (sk_rise && !busy)
        begin
            case (state)
                eeprom_pkg::ST_WAIT:
                begin
                    if (SERIAL_DATA_IN)
                    begin
                        next_state = eeprom_pkg::ST_OP;
                        next_cnt   = '0;
                    end
                end
                eeprom_pkg::ST_OP:
                begin
                    next_op  = {op[eeprom_pkg::OP_W-2:0], SERIAL_DATA_IN};
                    next_cnt = cnt + 1'b1;
                    if (cnt == OP_LAST)
                    begin
                        next_state = eeprom_pkg::ST_ADDR;
                        next_cnt   = '0;
                    end
                end
                eeprom_pkg::ST_ADDR:
                begin
                    next_addr = {addr[ADDR_W-2:0], SERIAL_DATA_IN};
                    next_cnt  = cnt + 1'b1;
                    if (cnt == ADDR_LAST)
                    begin
                        next_cnt   = '0;
                        next_state = eeprom_pkg::ST_DONE;
                        if (op == eeprom_pkg::OP_READ)
                        begin
                            next_state      = eeprom_pkg::ST_READ;
                            next_oe         = 1'b1;
                            next_do         = 1'b0;
                            next_bits_left  = '0;
                            next_fetch_addr = next_addr;
                            next_fetch_en   = 1'b1;
                        end
                        else if (op == eeprom_pkg::OP_WRITE)
                            next_state = eeprom_pkg::ST_DATA;
                        else if (op == eeprom_pkg::OP_ERASE)
                            next_pend = 1'b1;
                    end
                end
                eeprom_pkg::ST_DATA:
                begin
                    next_wdata = {wdata[W-2:0], SERIAL_DATA_IN};
                    next_cnt   = cnt + 1'b1;
                    if (cnt == DATA_LAST)
                    begin
                        next_pend  = 1'b1;
                        next_state = eeprom_pkg::ST_DONE;
                    end
                end
                eeprom_pkg::ST_READ:
                begin
                    if (bits_left == '0)
                    begin
                        // Next word from the prefetch buffer.
                        fifo_pop       = 1'b1;
                        next_do        = fifo_out_valid && fifo_out[W-1];
                        next_shreg     = {fifo_out[W-2:0], 1'b0};
                        next_bits_left = BITS_LAST;
                    end
                    else
                    begin
                        next_do        = shreg[W-1];
                        next_shreg     = {shreg[W-2:0], 1'b0};
                        next_bits_left = bits_left - 1'b1;
                    end
                end
                default:
                begin
                    next_state = state;
                end
            endcase
        end
    end

    // Registers the sequencer state and the pin drivers.
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            state       <= eeprom_pkg::ST_WAIT;
            cnt         <= '0;
            op          <= '0;
            addr        <= '0;
            wdata       <= '0;
            shreg       <= '0;
            bits_left   <= '0;
            busy_cnt    <= '0;
            sk_prev     <= 1'b0;
            cs_prev     <= 1'b0;
            fetch_en    <= 1'b0;
            fetch_addr  <= '0;
            pend        <= 1'b0;
            verify      <= 1'b0;
            DATA_OUT    <= 1'b0;
            DATA_OUT_OE <= 1'b0;
        end
        else
        begin
            state       <= next_state;
            cnt         <= next_cnt;
            op          <= next_op;
            addr        <= next_addr;
            wdata       <= next_wdata;
            shreg       <= next_shreg;
            bits_left   <= next_bits_left;
            busy_cnt    <= next_busy_cnt;
            sk_prev     <= SERIAL_CLOCK;
            cs_prev     <= CS;
            fetch_en    <= next_fetch_en;
            fetch_addr  <= next_fetch_addr;
            pend        <= next_pend;
            verify      <= next_verify;
            DATA_OUT    <= next_do;
            DATA_OUT_OE <= next_oe;
        end
    end

    // Array update at the start of a write or erase.
    always_ff @(posedge CLK)
    begin
        if (mem_we)
            mem[addr] <= (op == eeprom_pkg::OP_ERASE) ? '1 : wdata;
    end

endmodule : serial_eeprom

/* serial_eeprom_asserts.sv */
// Port checks for the serial EEPROM top module.
`timescale 1ns/1ns
module serial_eeprom_asserts #(
    parameter int PROG_CYCLES = 20
) (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic CS,
    input wire logic SERIAL_CLOCK,
    input wire logic SERIAL_DATA_IN,
    input wire logic DATA_OUT,
    input wire logic DATA_OUT_OE
);
    localparam int BUSY_MAX = PROG_CYCLES + 3;
    logic sclk_last;
    logic sclk_rise;
    logic oe_last;
    logic rise_last;
    logic in_status;
    // A serial clock rise that the device is bound to take.
    assign sclk_rise = CS & SERIAL_CLOCK & ~sclk_last;
    // Keeps the last cycle's pins and marks an output that a status check,
    // not a read, turned on; a read may see a high data-in bit freely.
    always_ff @(posedge CLK)
    begin
        sclk_last <= SERIAL_CLOCK;
        oe_last   <= DATA_OUT_OE;
        rise_last <= sclk_rise;
        if (SYS_RST || !CS || !DATA_OUT_OE)
            in_status <= 1'b0;
        else if (!oe_last && !rise_last)
            in_status <= 1'b1;
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    // A start bit offered while the ready level is shown.
    sequence ready_hit;
        DATA_OUT && DATA_OUT_OE && sclk_rise && SERIAL_DATA_IN && in_status;
    endsequence
    float_on_deselect_a: assert property (!CS |=> !DATA_OUT_OE)
        else $error("output on after deselect");
    standby_enable_a: assert property ($rose(DATA_OUT_OE) |-> $past(CS))
        else $error("output on while deselected");
    lead_low_a: assert property (
        $rose(DATA_OUT_OE) && $past(sclk_rise) |-> !DATA_OUT)
        else $error("read lead bit not low");
    enable_cause_a: assert property (
        $rose(DATA_OUT_OE) |-> $past(sclk_rise) || !$past(CS, 2))
        else $error("output on without cause");
    fall_cause_a: assert property (
        $fell(DATA_OUT) && DATA_OUT_OE && $past(DATA_OUT_OE)
        |-> $past(sclk_rise)) else $error("output fell without clock");
    ready_start_a: assert property (ready_hit |=> !DATA_OUT_OE)
        else $error("start bit in ready ignored");
    busy_ready_a: assert property (
        $rose(DATA_OUT_OE) && !DATA_OUT && !$past(sclk_rise)
        |-> ##[0:BUSY_MAX] (DATA_OUT || !CS)) else $error("busy too long");
    enable_stand_a: assert property (
        DATA_OUT_OE && CS && !sclk_rise |=> DATA_OUT_OE)
        else $error("output dropped while selected");
endmodule : serial_eeprom_asserts

/* host_model.sv */
// Behavioural host that drives chip select, serial clock and data in.
`timescale 1ns/1ns
module host_model (
    input  wire logic clk,
    input  wire logic data_out,
    input  wire logic data_out_oe,
    output logic      cs,
    output logic      serial_clock,
    output logic      serial_data_in
);
    // Deselected, with the serial clock standing low.
    initial
    begin
        cs = 1'b0;
        serial_clock = 1'b0;
        serial_data_in = 1'b0;
    end
    // Waits n edges and steps just past the last one.
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    // Selects with data in low, as a status check needs.
    task automatic select();
        cs = 1'b1;
        serial_data_in = 1'b0;
        tick(1);
    endtask : select
    // Deselects for 8 cycles; data in wanders, the clock only if noisy.
    task automatic deselect(input logic noisy);
        cs = 1'b0;
        repeat (8)
        begin
            serial_data_in = ~serial_data_in;
            serial_clock = noisy & ~serial_clock;
            tick(1);
        end
    endtask : deselect
    // One bit on a serial clock rise; output read 3 edges later.
    task automatic clock_bit(input logic b, output logic q, output logic oe);
        serial_data_in = b;
        tick(3);
        serial_clock = 1'b1;
        tick(3);
        q = data_out;
        oe = data_out_oe;
        serial_clock = 1'b0;
    endtask : clock_bit
    // Sends the low n bits of v, most significant first.
    task automatic send(input logic [31:0] v, input int n);
        logic q, oe;
        for (int i = n - 1; i >= 0; i--)
            clock_bit(v[i], q, oe);
    endtask : send
endmodule : host_model

/* serial_eeprom_tb.sv */
// Self-checking bench for the serial EEPROM command and read port.
`timescale 1ns/1ns
module serial_eeprom_tb;
    localparam int          PROG = 20;
    localparam logic [15:0] W_HI = 16'hb5a6;
    localparam logic [15:0] W_LO = 16'h6d9b;
    localparam logic [15:0] ERASED = 16'hffff; // An erased word reads all ones.
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic cs, serial_clock, serial_data_in, data_out, data_out_oe;
    int   miscompares = 0;
    int   comparisons = 0;
    serial_eeprom #(.PROG_CYCLES(PROG)) serial_eeprom_i (
        .CLK(clk), .SYS_RST(sys_rst), .CS(cs),
        .SERIAL_CLOCK(serial_clock), .SERIAL_DATA_IN(serial_data_in),
        .DATA_OUT(data_out), .DATA_OUT_OE(data_out_oe));
    host_model host_model_i (
        .clk(clk), .data_out(data_out), .data_out_oe(data_out_oe),
        .cs(cs), .serial_clock(serial_clock),
        .serial_data_in(serial_data_in));
    // Clock at 10 MHz.
    always #50 clk = ~clk;
    // Cuts a hung run short well past the expected length.
    always
    begin
        repeat (5000) @(posedge clk);
        miscompares++;
        end_sim();
    end
    task automatic end_sim();
        if (miscompares == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim
    // Compares one result, a bit being zero extended.
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: got %h", $time, got);
        end
    endtask : check
    // Clocks and data move while deselected; the output stays off.
    task automatic t_standby();
        host_model_i.deselect(1'b1);
        check({15'h0, data_out_oe}, 16'h0);
    endtask : t_standby
    // Write behind 3 dummy clocks; it starts at deselect.
    task automatic t_write(input logic [5:0] a, input logic [15:0] d);
        host_model_i.select();
        host_model_i.send({8'h01, eeprom_pkg::OP_WRITE, a, d}, 28);
        host_model_i.deselect(1'b0);
        check({15'h0, data_out_oe}, 16'h0);
    endtask : t_write
    // Erase of one word behind 3 dummy clocks; it starts at deselect.
    task automatic t_erase(input logic [5:0] a);
        host_model_i.select();
        host_model_i.send({24'h1, eeprom_pkg::OP_ERASE, a}, 12);
        host_model_i.deselect(1'b0);
        check({15'h0, data_out_oe}, 16'h0);
    endtask : t_erase
    // Opcode and address after a start bit, then n words, then deselect.
    task automatic read_rest(input logic [5:0] a, input logic [31:0] exp,
                             input int n);
        logic        q, oe;
        logic [15:0] w;
        host_model_i.send({25'h0, eeprom_pkg::OP_READ, a[5:1]}, 7);
        host_model_i.clock_bit(a[0], q, oe);
        check({14'h0, oe, q}, 16'h2);
        for (int k = 0; k < n; k++)
        begin
            for (int i = 15; i >= 0; i--)
                host_model_i.clock_bit(1'b0, w[i], oe);
            check(w, exp[31-16*k -: 16]);
        end
        host_model_i.deselect(1'b0);
        check({15'h0, data_out_oe}, 16'h0);
    endtask : read_rest
    // Status check: busy low, ready high, then a start bit and a read.
    task automatic t_status(input logic [5:0] a, input logic [31:0] exp,
                            input int n);
        int   t;
        logic q, oe;
        host_model_i.select();
        host_model_i.tick(2);
        check({14'h0, data_out_oe, data_out}, 16'h2);
        for (t = 0; t < PROG + 10 && data_out !== 1'b1; t++)
            host_model_i.tick(1);
        check({15'h0, data_out}, 16'h1);
        host_model_i.clock_bit(1'b1, q, oe);
        check({15'h0, oe}, 16'h0);
        read_rest(a, exp, n);
    endtask : t_status
    // Reset for 6 cycles, then the scenarios in turn.
    initial
    begin
        repeat (6) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        t_standby();
        t_write(6'h00, W_LO);
        t_status(6'h00, 32'h0, 0);
        t_write(6'h3f, W_HI);
        t_status(6'h3f, {W_HI, W_LO}, 2);
        t_erase(6'h00);
        t_status(6'h3f, {W_HI, ERASED}, 2);
        end_sim();
    end
endmodule : serial_eeprom_tb

bind serial_eeprom serial_eeprom_asserts #(.PROG_CYCLES(PROG_CYCLES))
    serial_eeprom_asserts_i (
    .CLK(CLK), .SYS_RST(SYS_RST), .CS(CS), .SERIAL_CLOCK(SERIAL_CLOCK),
    .SERIAL_DATA_IN(SERIAL_DATA_IN), .DATA_OUT(DATA_OUT),
    .DATA_OUT_OE(DATA_OUT_OE));
